//--- rpm_assertions.sv
// checker for the reset and power mode controller
`timescale 1ns/1ps
module rpm_chk #(
  parameter int unsigned POR_DELAY_CYCLES = rpm_pkg::POR_DELAY_CYC
) (
  // clock and reset
  input wire logic              CLK_SYS,
  input wire logic              RESET,
  // bus and cpu side
  input wire rpm_pkg::rpm_bus_t BUS_REQ,
  input wire logic [7:0]        RDATA,
  input wire logic              INSN_DONE,
  input wire logic              IRQ_WAKE,
  input wire logic              OTHER_RST,
  input wire logic              SYS_RST,
  input wire logic              CPU_CLK_EN,
  input wire logic              PERIPH_CLK_EN,
  input wire logic              OSC_EN,
  input wire logic              PC_LOAD,
  input wire logic [15:0]       FETCH_ADDR,
  input wire logic              CLK_SEL_INT,
  input wire logic              WDT_EN,
  input wire logic [3:0]        WDT_DIV,
  input wire logic [7:0]        STACK_PTR,
  // ports and pin
  input wire logic [7:0]        PORT_LATCH,
  input wire logic [7:0]        PORT_MODE,
  input wire logic              PULLUP_EN,
  input wire logic              SUPPLY_LOW,
  input wire logic              RST_PIN_O,
  input wire logic              RST_PIN_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // ran_r marks the first release, so later monitor exits are told apart
  logic        ran_r;
  logic [15:0] cnt_r;
  logic        pm_set;
  assign pm_set = BUS_REQ.wr && BUS_REQ.addr == 8'h87 && |BUS_REQ.wdata[1:0];
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ran_r <= 1'b0;
      cnt_r <= 16'h0;
    end else begin
      if (!SYS_RST) ran_r <= 1'b1;
      if (!ran_r) cnt_r <= cnt_r + 16'h1;
    end
  end
  a_mode_bits_zero: assert property (BUS_REQ.rd && BUS_REQ.addr == 8'h87 |=>
    RDATA[1:0] == 2'b00) else $error("mode select bits read nonzero");
  a_mode_entry: assert property (pm_set && INSN_DONE && !SYS_RST |=>
    !CPU_CLK_EN) else $error("cpu clock not gated after mode entry");
  a_stop_gates: assert property (!OSC_EN |->
    !CPU_CLK_EN && !PERIPH_CLK_EN) else $error("clocks run with oscillator off");
  a_stop_exit: assert property ($rose(OSC_EN) |-> ##[0:1] SYS_RST)
    else $error("stop left without reset");
  a_idle_wake: assert property (!CPU_CLK_EN && OSC_EN && !SYS_RST && IRQ_WAKE &&
    !OTHER_RST |=> CPU_CLK_EN) else $error("interrupt did not end idle");
  a_pin_only_rst: assert property (RST_PIN_OE |-> SYS_RST && !RST_PIN_O)
    else $error("reset pin pulled outside reset");
  a_rst_defaults: assert property (SYS_RST ##1 SYS_RST |->
    STACK_PTR == 8'h07 && PORT_LATCH == 8'hff && PORT_MODE == 8'h00 && !CPU_CLK_EN)
    else $error("reset values not held in reset");
  a_exit_state: assert property (PC_LOAD |-> $past(SYS_RST) && FETCH_ADDR == 16'h0000 &&
    CLK_SEL_INT && WDT_EN && WDT_DIV == 4'hc) else $error("bad state on reset exit");
  a_por_delay: assert property ($fell(SYS_RST) && !ran_r |->
    cnt_r >= POR_DELAY_CYCLES && cnt_r <= POR_DELAY_CYCLES + 3) else $error("power-up delay off");
  a_mon_quick: assert property (ran_r && RST_PIN_OE && $fell(SUPPLY_LOW) |->
    ##[2:4] !SYS_RST) else $error("monitor release late");
  a_pullup_on: assert property (PULLUP_EN)
    else $error("pullups off");
  cover property (pm_set && INSN_DONE && !SYS_RST);
  cover property ($fell(SYS_RST) && ran_r);
  cover property (!OSC_EN);
endmodule

bind rpm_top rpm_chk #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) u_rpm_chk (.*);

//--- rpm_pkg.sv
// shared constants, types and register map of the reset and power mode controller
package rpm_pkg;

  // register offsets on the 8-bit special register bus
  localparam logic [7:0] OFS_PWR_MODE   = 8'h87;
  localparam logic [7:0] OFS_MON_CTRL   = 8'hff;
  localparam logic [7:0] OFS_RST_CAUSE  = 8'hef;
  localparam logic [7:0] OFS_STACK_PTR  = 8'h81;
  localparam logic [7:0] OFS_PORT_LATCH = 8'h90;
  localparam logic [7:0] OFS_PORT_MODE  = 8'ha4;

  // internal data memory sits at addresses with bit 7 clear
  localparam int          RAM_AW    = 7;
  localparam int          RAM_DEPTH = 128;
  localparam int          RAM_SEL   = 7;

  // field positions
  localparam int          PM_IDLE_BIT  = 0;
  localparam int          PM_STOP_BIT  = 1;
  localparam int          PM_FLAG_LSB  = 2;
  localparam int          PM_FLAG_MSB  = 7;
  localparam int          MON_EN_BIT   = 7;
  localparam int          MON_STAT_BIT = 6;
  localparam int          RC_POR_BIT   = 1;

  // reset values
  localparam logic [5:0]  GP_FLAGS_RST   = 6'h00;
  localparam logic [7:0]  STACK_PTR_RST  = 8'h07;
  localparam logic [7:0]  PORT_LATCH_RST = 8'hff;
  localparam logic [7:0]  PORT_MODE_RST  = 8'h00;
  localparam logic [3:0]  WDT_DIV_RST    = 4'hc;
  localparam logic [15:0] FETCH_ADDR_RST = 16'h0000;

  // timing
  localparam int          CLK_PERIOD_NS = 40;
  localparam real         POR_DELAY_MS  = 0.3;
  localparam int          POR_DELAY_CYC = int'(POR_DELAY_MS * 1000000.0 / real'(CLK_PERIOD_NS));
  localparam int          CNT_W         = 16;

  typedef enum logic [4:0] {
    RS_POWER_UP   = 5'b00001,
    RS_RELEASE    = 5'b00010,
    RS_RUN        = 5'b00100,
    RS_MON_HOLD   = 5'b01000,
    RS_OTHER_HOLD = 5'b10000
  } rpm_rst_state_t;

  typedef enum logic [2:0] {
    PM_RUN  = 3'b001,
    PM_IDLE = 3'b010,
    PM_STOP = 3'b100
  } rpm_pm_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rpm_bus_t;

endpackage

//--- rpm_ram.sv
// internal data memory, never cleared by any reset
`timescale 1ns/1ps
module rpm_ram (
  // clock
  input  wire logic                      clk,
  input  wire logic                      ce,
  // access port
  input  wire logic                      we,
  input  wire logic [rpm_pkg::RAM_AW-1:0] addr,
  input  wire logic [7:0]                wdata,
  output logic      [7:0]                q
);
  import rpm_pkg::*;

  typedef struct packed {
    logic [RAM_DEPTH-1:0][7:0] mem;
    logic [7:0]                q;
  } rpm_ram_st_t;

  rpm_ram_st_t s_r;
  rpm_ram_st_t s_nxt;

  // no reset branch: contents must survive every reset
  always_comb begin
    s_nxt   = s_r;
    s_nxt.q = s_r.mem[addr];
    if (we) begin
      s_nxt.mem[addr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule

//--- rpm_supply_mon.sv
// supply monitor comparator model facing the controller
`timescale 1ns/1ps
module rpm_supply_mon #(
  parameter int RESP_NS = 7
) (
  // commanded supply dip
  input  wire logic dip,
  // comparator out, high at or below threshold
  output logic      supply_low
);
  initial supply_low = 1'b0;
  // moves off the clock grid so the synchroniser sees a true async edge
  always @(dip) supply_low <= #RESP_NS dip;
endmodule

//--- rpm_sync.sv
// two-stage synchroniser for the supply monitor comparator
`timescale 1ns/1ps
module rpm_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // level in and out
  input  wire logic d,
  output logic      q
);
  import rpm_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
  } rpm_sync_st_t;

  rpm_sync_st_t s_r;
  rpm_sync_st_t s_nxt;

  // reset value assumes supply good; power-up itself is covered by rst
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.sync;
endmodule

//--- rpm_top.sv
// reset sequencing, supply monitor reset and idle/stop control
// How it works
// - writing 1 to stop bit halts cpu and oscillator; bit reads 0
// - writing 1 to idle bit gates cpu clock only; bit reads 0
// - power mode bits 7..2 are six plain software flags, reset 0
// - reset halts cpu, reloads registers, forces ports, keeps the watchdog enabled
// - internal data memory is untouched by any reset
// - stack pointer reloads on every reset; stacked bytes stay in memory
// - port latches reset to all ones, open-drain, pullups on
// - power-up and monitor resets drive the reset pin low throughout
// - leaving reset clears pc, selects internal oscillator, fetches at zero
// - leaving reset enables watchdog clocked at system clock over twelve
// - after power-up the block waits a release delay before running
// - exit from power-up or monitor reset sets the power-up cause flag
// - any other reset clears the power-up cause flag
// - supply below threshold holds reset and pin low until it recovers
// - monitor enable set by power-up, kept through every other reset
// - monitor reset release skips the power-up delay
// - idle and stop start only once the setting instruction completes
// - enabled interrupt or reset ends idle and clears the idle bit
// - stop ends only through a reset, then the normal sequence runs
`timescale 1ns/1ps
module rpm_top #(
  parameter int unsigned POR_DELAY_CYCLES = rpm_pkg::POR_DELAY_CYC
) (
  // clock, reset, enable
  input  wire logic             CLK_SYS,
  input  wire logic             RESET,
  input  wire logic             CE,
  // register bus
  input  wire rpm_pkg::rpm_bus_t BUS_REQ,
  output logic      [7:0]       RDATA,
  // cpu side
  input  wire logic             INSN_DONE,
  input  wire logic             IRQ_WAKE,
  input  wire logic             OTHER_RST,
  output logic                  SYS_RST,
  output logic                  CPU_CLK_EN,
  output logic                  PERIPH_CLK_EN,
  output logic                  OSC_EN,
  output logic                  PC_LOAD,
  output logic      [15:0]      FETCH_ADDR,
  output logic                  CLK_SEL_INT,
  output logic                  WDT_EN,
  output logic      [3:0]       WDT_DIV,
  output logic      [7:0]       STACK_PTR,
  // ports
  output logic      [7:0]       PORT_LATCH,
  output logic      [7:0]       PORT_MODE,
  output logic                  PULLUP_EN,
  // supply monitor and reset pin
  input  wire logic             SUPPLY_LOW,
  output logic                  RST_PIN_O,
  output logic                  RST_PIN_OE
);
  import rpm_pkg::*;

  typedef struct packed {
    rpm_rst_state_t rst_state;
    rpm_pm_state_t  pm_state;
    logic           idle_pend;
    logic           stop_pend;
    logic [5:0]     gp_flags;
    logic           mon_en;
    logic           mon_sel;
    logic           por_flag;
    logic [7:0]     stack_ptr;
    logic [7:0]     port_latch;
    logic [7:0]     port_mode;
    logic [CNT_W-1:0] dly_cnt;
    logic [7:0]     rdata;
    logic           rd_ram;
    logic           pc_load;
    logic           clk_sel_int;
    logic           wdt_en;
  } rpm_st_t;

  localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(POR_DELAY_CYCLES - 1);

  // power-up value of the whole state
  localparam rpm_st_t ST_POR = '{
    rst_state:   RS_POWER_UP,
    pm_state:    PM_RUN,
    idle_pend:   1'b0,
    stop_pend:   1'b0,
    gp_flags:    GP_FLAGS_RST,
    mon_en:      1'b1,
    mon_sel:     1'b0,
    por_flag:    1'b0,
    stack_ptr:   STACK_PTR_RST,
    port_latch:  PORT_LATCH_RST,
    port_mode:   PORT_MODE_RST,
    dly_cnt:     '0,
    rdata:       8'h00,
    rd_ram:      1'b0,
    pc_load:     1'b0,
    clk_sel_int: 1'b1,
    wdt_en:      1'b1
  };

  rpm_st_t    s_r;
  rpm_st_t    s_nxt;
  logic       supply_low_s;
  logic       in_reset;
  logic       mon_trip;
  logic       wr_hit;
  logic       ram_we;
  logic [7:0] ram_q;

  // comparator is asynchronous to the system clock
  rpm_sync u_sync (
    .clk (CLK_SYS),
    .rst (RESET),
    .ce  (CE),
    .d   (SUPPLY_LOW),
    .q   (supply_low_s)
  );

  // memory writes blocked while in reset, never cleared
  assign ram_we = BUS_REQ.wr & ~BUS_REQ.addr[RAM_SEL] & ~in_reset;

  rpm_ram u_ram (
    .clk   (CLK_SYS),
    .ce    (CE),
    .we    (ram_we),
    .addr  (BUS_REQ.addr[RAM_AW-1:0]),
    .wdata (BUS_REQ.wdata),
    .q     (ram_q)
  );

  assign in_reset = (s_r.rst_state != RS_RUN);
  // monitor only resets once both enabled and selected as a source
  assign mon_trip = s_r.mon_en & s_r.mon_sel & supply_low_s;
  assign wr_hit   = BUS_REQ.wr & ~in_reset;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.pc_load = 1'b0;

    // reset sequencer
    case (s_r.rst_state)
      RS_POWER_UP: begin
        s_nxt.rst_state = RS_RELEASE;
        s_nxt.dly_cnt   = '0;
      end
      RS_RELEASE: begin
        if (s_r.dly_cnt >= DLY_LAST) begin
          s_nxt.rst_state = RS_RUN;
          s_nxt.pc_load   = 1'b1;
          s_nxt.por_flag  = 1'b1;
        end else begin
          s_nxt.dly_cnt = s_r.dly_cnt + 1'b1;
        end
      end
      RS_RUN: begin
        if (mon_trip) begin
          s_nxt.rst_state = RS_MON_HOLD;
        end else if (OTHER_RST) begin
          s_nxt.rst_state = RS_OTHER_HOLD;
        end
      end
      RS_MON_HOLD: begin
        // straight back to run, no release delay
        if (!supply_low_s) begin
          s_nxt.rst_state = RS_RUN;
          s_nxt.pc_load   = 1'b1;
          s_nxt.por_flag  = 1'b1;
        end
      end
      RS_OTHER_HOLD: begin
        if (mon_trip) begin
          s_nxt.rst_state = RS_MON_HOLD;
        end else if (!OTHER_RST) begin
          s_nxt.rst_state = RS_RUN;
          s_nxt.pc_load   = 1'b1;
          s_nxt.por_flag  = 1'b0;
        end
      end
      default: begin
        s_nxt.rst_state = RS_POWER_UP;
      end
    endcase

    if (in_reset) begin
      // registers reload every cycle of reset; mon_en and mon_sel are kept
      s_nxt.pm_state    = PM_RUN;
      s_nxt.idle_pend   = 1'b0;
      s_nxt.stop_pend   = 1'b0;
      s_nxt.gp_flags    = GP_FLAGS_RST;
      s_nxt.stack_ptr   = STACK_PTR_RST;
      s_nxt.port_latch  = PORT_LATCH_RST;
      s_nxt.port_mode   = PORT_MODE_RST;
      s_nxt.clk_sel_int = 1'b1;
      s_nxt.wdt_en      = 1'b1;
    end else begin
      // register writes
      if (wr_hit) begin
        case (BUS_REQ.addr)
          OFS_PWR_MODE: begin
            s_nxt.gp_flags = BUS_REQ.wdata[PM_FLAG_MSB:PM_FLAG_LSB];
            if (BUS_REQ.wdata[PM_STOP_BIT]) begin
              s_nxt.stop_pend = 1'b1;
            end
            if (BUS_REQ.wdata[PM_IDLE_BIT]) begin
              s_nxt.idle_pend = 1'b1;
            end
          end
          OFS_MON_CTRL: begin
            s_nxt.mon_en = BUS_REQ.wdata[MON_EN_BIT];
          end
          OFS_RST_CAUSE: begin
            // a 1 here selects the monitor; the cause flag itself is hardware owned
            if (BUS_REQ.wdata[RC_POR_BIT]) begin
              s_nxt.mon_sel = 1'b1;
            end
          end
          OFS_STACK_PTR: begin
            s_nxt.stack_ptr = BUS_REQ.wdata;
          end
          OFS_PORT_LATCH: begin
            s_nxt.port_latch = BUS_REQ.wdata;
          end
          OFS_PORT_MODE: begin
            s_nxt.port_mode = BUS_REQ.wdata;
          end
          default: begin
          end
        endcase
      end

      // power mode changes wait for the setting instruction to finish
      case (s_r.pm_state)
        PM_RUN: begin
          if (INSN_DONE && (s_nxt.stop_pend || s_nxt.idle_pend)) begin
            s_nxt.pm_state  = s_nxt.stop_pend ? PM_STOP : PM_IDLE;
            s_nxt.stop_pend = 1'b0;
            s_nxt.idle_pend = 1'b0;
          end
        end
        PM_IDLE: begin
          if (IRQ_WAKE) begin
            s_nxt.pm_state = PM_RUN;
          end
        end
        PM_STOP: begin
          s_nxt.pm_state = PM_STOP;
        end
        default: begin
          s_nxt.pm_state = PM_RUN;
        end
      endcase
    end

    // read path; data stand the cycle after the strobe
    s_nxt.rd_ram = BUS_REQ.rd & ~BUS_REQ.addr[RAM_SEL];
    s_nxt.rdata  = 8'h00;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        OFS_PWR_MODE: begin
          // mode select bits always read 0
          s_nxt.rdata = {s_r.gp_flags, 2'b00};
        end
        OFS_MON_CTRL: begin
          s_nxt.rdata[MON_EN_BIT]   = s_r.mon_en;
          s_nxt.rdata[MON_STAT_BIT] = ~supply_low_s;
        end
        OFS_RST_CAUSE: begin
          s_nxt.rdata[RC_POR_BIT] = s_r.por_flag;
        end
        OFS_STACK_PTR: begin
          s_nxt.rdata = s_r.stack_ptr;
        end
        OFS_PORT_LATCH: begin
          s_nxt.rdata = s_r.port_latch;
        end
        OFS_PORT_MODE: begin
          s_nxt.rdata = s_r.port_mode;
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_r <= ST_POR;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign RDATA         = s_r.rd_ram ? ram_q : s_r.rdata;
  assign SYS_RST       = in_reset;
  assign CPU_CLK_EN    = ~in_reset & (s_r.pm_state == PM_RUN);
  assign PERIPH_CLK_EN = ~in_reset & (s_r.pm_state != PM_STOP);
  assign OSC_EN        = (s_r.pm_state != PM_STOP);
  assign PC_LOAD       = s_r.pc_load;
  assign FETCH_ADDR    = FETCH_ADDR_RST;
  assign CLK_SEL_INT   = s_r.clk_sel_int;
  assign WDT_EN        = s_r.wdt_en;
  assign WDT_DIV       = WDT_DIV_RST;
  assign STACK_PTR     = s_r.stack_ptr;
  assign PORT_LATCH    = s_r.port_latch;
  assign PORT_MODE     = s_r.port_mode;
  assign PULLUP_EN     = 1'b1;
  // open-drain pin: only ever pulls low
  assign RST_PIN_O     = 1'b0;
  assign RST_PIN_OE    = (s_r.rst_state == RS_POWER_UP) | (s_r.rst_state == RS_RELEASE)
                         | (s_r.rst_state == RS_MON_HOLD);
endmodule

//--- tb_rpm_top.sv
// self-checking bench for the reset and power mode controller
`timescale 1ns/1ps
module tb_rpm_top;
  import rpm_pkg::*;
  logic       CLK_SYS, RESET, INSN_DONE, IRQ_WAKE, OTHER_RST, dip;
  rpm_bus_t   BUS_REQ;
  logic [7:0] RDATA, STACK_PTR, PORT_LATCH, PORT_MODE;
  logic       SYS_RST, CPU_CLK_EN, PERIPH_CLK_EN, OSC_EN, SUPPLY_LOW, RST_PIN_OE;
  int         mismatches = 0;
  int         cmp_count = 0;

  rpm_top #(.POR_DELAY_CYCLES(8)) u_rpm_top (
    .CLK_SYS, .RESET, .CE(1'b1), .BUS_REQ, .RDATA, .INSN_DONE, .IRQ_WAKE, .OTHER_RST,
    .SYS_RST, .CPU_CLK_EN, .PERIPH_CLK_EN, .OSC_EN, .PC_LOAD(), .FETCH_ADDR(),
    .CLK_SEL_INT(), .WDT_EN(), .WDT_DIV(), .STACK_PTR, .PORT_LATCH, .PORT_MODE,
    .PULLUP_EN(), .SUPPLY_LOW, .RST_PIN_O(), .RST_PIN_OE);
  rpm_supply_mon u_mon (.dip, .supply_low(SUPPLY_LOW));

  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  // ins marks the write as the mode-setting instruction completing
  task automatic wr(input logic [7:0] a, d, input logic ins = 1'b0);
    @(posedge CLK_SYS);
    BUS_REQ <= '{a, d, 1'b1, 1'b0};
    INSN_DONE <= ins;
    @(posedge CLK_SYS);
    BUS_REQ <= '0;
    INSN_DONE <= 1'b0;
    #1;
  endtask
  task automatic rd(input string n, input logic [7:0] a, e, m = 8'hff);
    @(posedge CLK_SYS);
    BUS_REQ <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge CLK_SYS);
    BUS_REQ <= '0;
    #1;
    chk(n, RDATA & m, e);
  endtask
  task automatic wrel();
    for (int i = 0; i < 40 && SYS_RST !== 1'b0; i++) cyc(1);
    chk("released", {7'h0, SYS_RST}, 8'h00);
  endtask
  task automatic rst_other();
    @(posedge CLK_SYS);
    OTHER_RST <= 1'b1;
    cyc(3);
    chk("other rst", {6'h0, SYS_RST, RST_PIN_OE}, 8'h02);
    @(posedge CLK_SYS);
    OTHER_RST <= 1'b0;
    wrel();
  endtask
  task automatic clks(input logic [2:0] e);
    chk("clocks", {5'h0, CPU_CLK_EN, PERIPH_CLK_EN, OSC_EN}, {5'h0, e});
  endtask

  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  initial begin
    BUS_REQ = '0;
    INSN_DONE = 1'b0;
    IRQ_WAKE = 1'b0;
    OTHER_RST = 1'b0;
    dip = 1'b0;
    RESET = 1'b1;
    repeat (10) @(posedge CLK_SYS);
    RESET <= 1'b0;
    wrel();
    rd("por flag", 8'hef, 8'h02, 8'h02);
    rd("mode", 8'h87, 8'h00);
    rd("stack", 8'h81, 8'h07);
    rd("monitor", 8'hff, 8'hc0, 8'hc0);
    chk("latch", PORT_LATCH, 8'hff);
    chk("port mode", PORT_MODE, 8'h00);
    // mode bits left clear: a pending stop would fire at the next completed instruction
    wr(8'h87, 8'hfc);
    rd("mode flags", 8'h87, 8'hfc);
    wr(8'h10, 8'h5a);
    wr(8'h81, 8'h30);
    wr(8'h90, 8'h00);
    wr(8'ha4, 8'h3c);
    chk("stack wr", STACK_PTR, 8'h30);
    chk("latch wr", PORT_LATCH, 8'h00);
    chk("port mode wr", PORT_MODE, 8'h3c);
    // idle entry and interrupt wake
    wr(8'h87, 8'hfd, 1'b1);
    cyc(1);
    clks(3'b011);
    @(posedge CLK_SYS);
    IRQ_WAKE <= 1'b1;
    @(posedge CLK_SYS);
    IRQ_WAKE <= 1'b0;
    cyc(1);
    clks(3'b111);
    rd("idle clear", 8'h87, 8'hfc);
    rst_other();
    rd("por clear", 8'hef, 8'h00, 8'h02);
    rd("stack rst", 8'h81, 8'h07);
    rd("mode rst", 8'h87, 8'h00);
    rd("ram kept", 8'h10, 8'h5a);
    chk("latch rst", PORT_LATCH, 8'hff);
    chk("port mode rst", PORT_MODE, 8'h00);
    // stop ignores interrupts, leaves only by reset
    wr(8'h87, 8'h02, 1'b1);
    cyc(3);
    clks(3'b000);
    rd("stop reads 0", 8'h87, 8'h00);
    @(posedge CLK_SYS);
    IRQ_WAKE <= 1'b1;
    @(posedge CLK_SYS);
    IRQ_WAKE <= 1'b0;
    cyc(2);
    clks(3'b000);
    rst_other();
    cyc(1);
    clks(3'b111);
    wr(8'hff, 8'h00);
    rst_other();
    rd("mon off kept", 8'hff, 8'h00, 8'h80);
    // enable, let the monitor settle, only then select it
    wr(8'hff, 8'h80);
    cyc(4);
    wr(8'hef, 8'h02);
    @(posedge CLK_SYS);
    dip <= 1'b1;
    cyc(5);
    chk("mon hold", {6'h0, SYS_RST, RST_PIN_OE}, 8'h03);
    rd("supply bad", 8'hff, 8'h00, 8'h40);
    @(posedge CLK_SYS);
    dip <= 1'b0;
    cyc(5);
    chk("fast exit", {7'h0, SYS_RST}, 8'h00);
    rd("por again", 8'hef, 8'h02, 8'h02);
    rd("ram dip", 8'h10, 8'h5a);
    rd("mon kept", 8'hff, 8'h80, 8'h80);
    // a fresh power-up turns the monitor back on
    wr(8'hff, 8'h00);
    @(posedge CLK_SYS);
    RESET <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    RESET <= 1'b0;
    wrel();
    rd("por mon on", 8'hff, 8'h80, 8'h80);
    rd("por flag 2", 8'hef, 8'h02, 8'h02);
    conclude();
  end
endmodule
